// [design/pec_comparator.sv]
/*
  Protection element comparator with AXI4-Lite settings port.
  Assumes channel samples, tick and command inputs synchronous to clk.
*/
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
// What this block does
// [R01] Flag high while quantity inside pickup range
// [R02] Pickup while above setting, operate after delay
// [R03] Digital variant compares logic state input
// [R04] Six setting groups, active one governs
// [R05] Control class ignores active group
// [R06] Per-unit base from nominal CT/VT
// [R07] Mixed ratios rescaled, larger ratio is base
// [R08] Element idle unless enabled, default disabled
// [R09] Pickup delay holds off operate
// [R10] Reset delay holds operate after dropout
// [R11] Outputs zero until run asserted
// [R12] Run low clears all outputs immediately; a latched target is held until reset command
// [R13] Block input forms part of run
// [R14] Target disabled gives no indication
// [R15] Self-reset target follows operate
// [R16] Latched target held until reset command
// [R17] Events enabled emit pickup, dropout, operate
// [R18] Dropout event on pickup fall; here none when run low clears pickup
// [R19] Currents ratio-matched before summation
// [R20] Source picks currents, ground, voltages
// [R21] Sum or difference per CT polarity
// [R22] Delays count ticks, zero acts same tick
`timescale 1ns/1ps
`default_nettype none

module pec_comparator
  import pec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tick,
  input  wire logic              runIn,
  input  wire logic              blockIn,
  input  wire logic              digitalIn,
  input  wire logic              resetCmd,
  input  wire logic [2:0]        activeGroup,
  input  wire pec_chan_t         chan,
  output logic                   pickupFlag,
  output logic                   operateFlag,
  output logic                   targetOut,
  output pec_evt_t               events
);

  function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    mergeBytes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : mergeBytes
  // Ratio match each CT into primary units, then sum or subtract
  function automatic logic signed [33:0] sumCt(input logic signed [15:0] a, input logic signed [15:0] b,
                                               input logic [15:0] r1, input logic [15:0] r2,
                                               input logic u1, input logic u2, input logic diff);
    logic signed [33:0] pa;
    logic signed [33:0] pb;
    pa = u1 ? 34'(a) * $signed({18'h00000, r1}) : 34'sh000000000;
    pb = u2 ? 34'(b) * $signed({18'h00000, r2}) : 34'sh000000000;
    sumCt = diff ? pa - pb : pa + pb;
  endfunction : sumCt
  function automatic logic [33:0] absVal(input logic signed [33:0] v);
    absVal = v[33] ? 34'(-v) : 34'(v);
  endfunction : absVal
  logic [PEC_CTRL_WIDTH-1:0] ctrl_reg;
  logic [15:0]               ct1Ratio_reg;
  logic [15:0]               ct2Ratio_reg;
  logic [15:0]               nomSec_reg;
  logic [15:0]               nomVt_reg;
  pec_set_t                  grpSet_reg [PEC_NUM_GROUPS];
  pec_set_t                  ctlSet_reg;
  logic              awHeld_reg;
  logic              wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]       wData_reg;
  logic [3:0]        wStrb_reg;
  logic              pkp_reg;
  logic              op_reg;
  logic              tgt_reg;
  logic [15:0]       cnt_reg;
  pec_evt_t          evt_reg;

  // Control fields
  wire       fnEn      = ctrl_reg[PEC_CTRL_FNEN];
  wire       evEn      = ctrl_reg[PEC_CTRL_EVEN];
  wire       isDigital = ctrl_reg[PEC_CTRL_DIGITAL];
  wire       isControl = ctrl_reg[PEC_CTRL_CLASS];
  wire       ctDiff    = ctrl_reg[PEC_CTRL_CTDIFF];
  wire       underMode = ctrl_reg[PEC_CTRL_UNDER];
  wire       useCt1    = ctrl_reg[PEC_CTRL_USECT1];
  wire       useCt2    = ctrl_reg[PEC_CTRL_USECT2];
  wire pec_tgt_t tgtMode = pec_tgt_t'(ctrl_reg[PEC_CTRL_TGT_LO +: 2]);
  wire pec_qty_t qtySel  = pec_qty_t'(ctrl_reg[PEC_CTRL_QTY_LO +: 2]);

  // Run supervision
  wire run = fnEn & runIn & ~blockIn;  // [R08] [R13]

  // Setting set selection
  wire       grpValid = (activeGroup >= 3'h1) && (activeGroup <= 3'h6);
  wire [2:0] grpIdx   = grpValid ? activeGroup - 3'h1 : 3'h0;  // [R04]
  wire pec_set_t actSet = isControl ? ctlSet_reg : grpSet_reg[grpIdx];  // [R04] [R05]

  // Source quantity
  wire              isCurrent = (qtySel == PEC_QTY_PHASE) || (qtySel == PEC_QTY_GND);
  wire [15:0]       baseRatio = (useCt2 && (ct2Ratio_reg > ct1Ratio_reg)) || !useCt1 ?
                                ct2Ratio_reg : ct1Ratio_reg;  // [R07]
  wire signed [33:0] phSum = sumCt(chan.ct1Phase, chan.ct2Phase, ct1Ratio_reg, ct2Ratio_reg,
                                   useCt1, useCt2, ctDiff);  // [R19] [R21]
  wire signed [33:0] gnSum = sumCt(chan.ct1Gnd, chan.ct2Gnd, ct1Ratio_reg, ct2Ratio_reg,
                                   useCt1, useCt2, ctDiff);  // [R19] [R21]
  wire [33:0]       mag = (qtySel == PEC_QTY_PHASE) ? absVal(phSum) :
                          (qtySel == PEC_QTY_GND)   ? absVal(gnSum) :
                          (qtySel == PEC_QTY_VPH)   ? absVal(34'(chan.vtPhase)) :
                                                      absVal(34'(chan.vtAux));  // [R20]

  // Per-unit threshold, compared at the fixed-point scale of the pickup setting
  wire [31:0] puNom     = actSet.pickup * (isCurrent ? nomSec_reg : nomVt_reg);  // [R06]
  wire [47:0] threshold = isCurrent ? puNom * baseRatio : {16'h0000, puNom};  // [R06] [R07]
  wire [47:0] magScaled = {6'h00, mag, 8'h00};
  wire        analogIn  = underMode ? (magScaled <= threshold) : (magScaled >= threshold);  // [R01] [R02]
  wire        inRange   = isDigital ? digitalIn : analogIn;  // [R03]

  // Delay timers
  logic        pkpNext;
  logic        opNext;
  logic [15:0] cntNext;
  always_comb begin
    pkpNext = pkp_reg;
    opNext  = op_reg;
    cntNext = cnt_reg;
    if (!run) begin
      pkpNext = 1'b0;  // [R11] [R12]
      opNext  = 1'b0;
      cntNext = 16'h0000;
    end else if (tick) begin
      pkpNext = inRange;  // [R01]
      cntNext = 16'h0000;
      if (inRange != op_reg) begin
        if (cnt_reg >= (inRange ? actSet.pkpDelay : actSet.rstDelay)) begin
          opNext = inRange;  // [R09] [R10] [R22]
        end else begin
          cntNext = cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Target indication, a new operate wins over reset
  logic tgtNext;
  always_comb begin
    unique case (tgtMode)
      PEC_TGT_SELF:  tgtNext = opNext;  // [R15]
      PEC_TGT_LATCH: tgtNext = opNext | (tgt_reg & ~resetCmd);  // [R16]
      default:       tgtNext = 1'b0;  // [R14]
    endcase
  end

  pec_evt_t evtNext;
  assign evtNext.pickupEvent  = evEn & pkpNext & ~pkp_reg;  // [R17]
  assign evtNext.dropoutEvent = evEn & run & pkp_reg & ~pkpNext;  // [R17] [R18]
  assign evtNext.operateEvent = evEn & opNext & ~op_reg;  // [R17]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pkp_reg <= 1'b0;
      op_reg  <= 1'b0;
      cnt_reg <= 16'h0000;
      tgt_reg <= 1'b0;
      evt_reg <= '0;
    end else begin
      pkp_reg <= pkpNext;
      op_reg  <= opNext;
      cnt_reg <= cntNext;
      tgt_reg <= tgtNext;
      evt_reg <= evtNext;
    end
  end

  assign pickupFlag  = pkp_reg;
  assign operateFlag = op_reg;
  assign targetOut   = tgt_reg;
  assign events      = evt_reg;

  // Write channel
  logic awRdy_reg;
  logic wRdy_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  wire awFire = awRdy_reg & s_axi_awvalid;
  wire wFire  = wRdy_reg & s_axi_wvalid;
  wire doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
  wire bDone   = bValid_reg & s_axi_bready;

  wire [7:0] wa        = 8'(awAddr_reg);
  wire       wGrpHit   = (wa >= PEC_OFF_GRPBASE) && (wa < PEC_OFF_CTLSET);
  wire [7:0] wGrpOff   = wa - PEC_OFF_GRPBASE;
  wire [2:0] wGrpIdx   = 3'(wGrpOff >> 4);
  wire [1:0] wGrpWord  = wGrpOff[3:2];
  wire       wCtlHit   = (wa >= PEC_OFF_CTLSET) && (wa < PEC_OFF_CTLSET + PEC_OFF_GRPSTEP);
  wire [1:0] wCtlWord  = wa[3:2];
  wire       wSetOk    = (wGrpHit && wGrpIdx < 3'(PEC_NUM_GROUPS) && wGrpWord != 2'h3) ||
                         (wCtlHit && wCtlWord != 2'h3);
  wire       wMapped   = (wa == PEC_OFF_CTRL) || (wa == PEC_OFF_STATUS) || (wa == PEC_OFF_CT1RATIO) ||
                         (wa == PEC_OFF_CT2RATIO) || (wa == PEC_OFF_NOMSEC) || (wa == PEC_OFF_NOMVT) ||
                         (wSetOk && wa[1:0] == 2'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awRdy_reg  <= 1'b0;
      wRdy_reg   <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg  <= PEC_RESP_OKAY;
    end else begin
      awRdy_reg <= ~awHeld_reg & ~awFire & ~bValid_reg;
      wRdy_reg  <= ~wHeld_reg & ~wFire & ~bValid_reg;
      if (awFire) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (bDone) begin
        awHeld_reg <= 1'b0;
      end
      if (wFire) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (bDone) begin
        wHeld_reg <= 1'b0;
      end
      if (doWrite) begin
        bValid_reg <= 1'b1;
        bResp_reg  <= wMapped ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
      end else if (bDone) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  // Settings storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= PEC_CTRL_RST;  // [R08]
      ct1Ratio_reg <= PEC_RATIO_RST;
      ct2Ratio_reg <= PEC_RATIO_RST;
      nomSec_reg   <= PEC_NOM_RST;
      nomVt_reg    <= PEC_NOM_RST;
      ctlSet_reg   <= {3{PEC_SET_RST}};
      for (int g = 0; g < PEC_NUM_GROUPS; g++) begin
        grpSet_reg[g] <= {3{PEC_SET_RST}};
      end
    end else if (doWrite && wMapped) begin
      if (wa == PEC_OFF_CTRL) begin
        ctrl_reg <= {wStrb_reg[1] ? wData_reg[11:8] : ctrl_reg[11:8],
                     wStrb_reg[0] ? wData_reg[7:0]  : ctrl_reg[7:0]};
      end
      if (wa == PEC_OFF_CT1RATIO) ct1Ratio_reg <= mergeBytes(ct1Ratio_reg, wData_reg, wStrb_reg);
      if (wa == PEC_OFF_CT2RATIO) ct2Ratio_reg <= mergeBytes(ct2Ratio_reg, wData_reg, wStrb_reg);
      if (wa == PEC_OFF_NOMSEC)   nomSec_reg   <= mergeBytes(nomSec_reg, wData_reg, wStrb_reg);
      if (wa == PEC_OFF_NOMVT)    nomVt_reg    <= mergeBytes(nomVt_reg, wData_reg, wStrb_reg);
      if (wGrpHit) begin
        unique case (wGrpWord)
          2'h0:    grpSet_reg[wGrpIdx].pickup   <= mergeBytes(grpSet_reg[wGrpIdx].pickup, wData_reg, wStrb_reg);
          2'h1:    grpSet_reg[wGrpIdx].pkpDelay <= mergeBytes(grpSet_reg[wGrpIdx].pkpDelay, wData_reg, wStrb_reg);
          default: grpSet_reg[wGrpIdx].rstDelay <= mergeBytes(grpSet_reg[wGrpIdx].rstDelay, wData_reg, wStrb_reg);
        endcase
      end
      if (wCtlHit) begin
        unique case (wCtlWord)
          2'h0:    ctlSet_reg.pickup   <= mergeBytes(ctlSet_reg.pickup, wData_reg, wStrb_reg);
          2'h1:    ctlSet_reg.pkpDelay <= mergeBytes(ctlSet_reg.pkpDelay, wData_reg, wStrb_reg);
          default: ctlSet_reg.rstDelay <= mergeBytes(ctlSet_reg.rstDelay, wData_reg, wStrb_reg);
        endcase
      end
    end
  end

  assign s_axi_awready = awRdy_reg;
  assign s_axi_wready  = wRdy_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;

  // Read channel
  logic        arRdy_reg;
  logic        rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0]  rResp_reg;
  wire arFire = arRdy_reg & s_axi_arvalid;

  wire [7:0] ra       = 8'(s_axi_araddr);
  wire       rGrpHit  = (ra >= PEC_OFF_GRPBASE) && (ra < PEC_OFF_CTLSET);
  wire [7:0] rGrpOff  = ra - PEC_OFF_GRPBASE;
  wire [2:0] rGrpIdx  = 3'(rGrpOff >> 4);
  wire [1:0] rGrpWord = rGrpOff[3:2];
  wire       rCtlHit  = (ra >= PEC_OFF_CTLSET) && (ra < PEC_OFF_CTLSET + PEC_OFF_GRPSTEP);
  pec_set_t  rSet;
  assign rSet = rCtlHit ? ctlSet_reg : grpSet_reg[rGrpIdx < 3'(PEC_NUM_GROUPS) ? rGrpIdx : 3'h0];
  wire       rSetOk   = ((rGrpHit && rGrpIdx < 3'(PEC_NUM_GROUPS)) || rCtlHit) && rGrpWord != 2'h3;
  wire [15:0] rSetVal = (rGrpWord == 2'h0) ? rSet.pickup : (rGrpWord == 2'h1) ? rSet.pkpDelay : rSet.rstDelay;
  wire [31:0] statusWord = {21'h000000, activeGroup, run, tgt_reg, op_reg, pkp_reg, cnt_reg == 16'h0000,
                            inRange, isControl, 1'b0};

  logic [31:0] rDataNext;
  logic        rOk;
  always_comb begin
    rDataNext = 32'h00000000;
    rOk       = 1'b1;
    if (ra[1:0] != 2'h0) begin
      rOk = 1'b0;
    end else if (ra == PEC_OFF_CTRL) begin
      rDataNext = {20'h00000, ctrl_reg};
    end else if (ra == PEC_OFF_STATUS) begin
      rDataNext = statusWord;
    end else if (ra == PEC_OFF_CT1RATIO) begin
      rDataNext = {16'h0000, ct1Ratio_reg};
    end else if (ra == PEC_OFF_CT2RATIO) begin
      rDataNext = {16'h0000, ct2Ratio_reg};
    end else if (ra == PEC_OFF_NOMSEC) begin
      rDataNext = {16'h0000, nomSec_reg};
    end else if (ra == PEC_OFF_NOMVT) begin
      rDataNext = {16'h0000, nomVt_reg};
    end else if (rSetOk) begin
      rDataNext = {16'h0000, rSetVal};
    end else begin
      rOk = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arRdy_reg  <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg  <= 32'h00000000;
      rResp_reg  <= PEC_RESP_OKAY;
    end else begin
      arRdy_reg <= ~rValid_reg & ~arFire;
      if (arFire) begin
        rValid_reg <= 1'b1;
        rData_reg  <= rDataNext;
        rResp_reg  <= rOk ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
      end else if (rValid_reg && s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_arready = arRdy_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  // Checks
  AST_RUN_CLEARS: assert property (@(posedge clk) disable iff (!resetn)  // [R11] [R12] [R13]
    !run |=> !pickupFlag && !operateFlag && events == '0) else $error("outputs not cleared while run is low");
  AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (!resetn)  // [R08]
    operateFlag |-> $past(fnEn) && $past(runIn) && !$past(blockIn)) else $error("operate without enable and run");
  AST_TGT_OFF: assert property (@(posedge clk) disable iff (!resetn)  // [R14]
    tgtMode == PEC_TGT_OFF |=> !targetOut) else $error("target shown while disabled");
  AST_TGT_SELF: assert property (@(posedge clk) disable iff (!resetn)  // [R15]
    tgtMode == PEC_TGT_SELF |=> targetOut == operateFlag) else $error("self-reset target does not follow operate");
  AST_TGT_LATCH: assert property (@(posedge clk) disable iff (!resetn)  // [R16]
    tgtMode == PEC_TGT_LATCH && targetOut && !resetCmd |=> targetOut)
    else $error("latched target lost without reset");
  AST_NO_EVENTS: assert property (@(posedge clk) disable iff (!resetn)  // [R17]
    !evEn |=> events == '0) else $error("event emitted while events disabled");
  AST_DROPOUT_EDGE: assert property (@(posedge clk) disable iff (!resetn)  // [R18]
    events.dropoutEvent |-> $fell(pickupFlag)) else $error("dropout event without pickup fall");
  AST_PICKUP_EDGE: assert property (@(posedge clk) disable iff (!resetn)  // [R17]
    events.pickupEvent |-> $rose(pickupFlag)) else $error("pickup event without pickup rise");
  AST_OPERATE_EDGE: assert property (@(posedge clk) disable iff (!resetn)  // [R09]
    $rose(operateFlag) |-> $past(pickupFlag) || ($past(actSet.pkpDelay) == 16'h0000))
    else $error("operate rose before pickup delay");
  AST_ZERO_DELAY: assert property (@(posedge clk) disable iff (!resetn)  // [R22] [R02]
    run && tick && inRange && actSet.pkpDelay == 16'h0000 |=> operateFlag && pickupFlag)
    else $error("zero pickup delay did not operate on same tick");

endmodule : pec_comparator

`default_nettype wire

// [design/pec_pkg.sv]
/*
  Shared constants and types for the protection element comparator.
  Assumes a 32-bit AXI4-Lite register bus and 16-bit signed channel samples.
*/
package pec_pkg;

  // Register byte offsets
  localparam logic [7:0] PEC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] PEC_OFF_STATUS   = 8'h04;
  localparam logic [7:0] PEC_OFF_CT1RATIO = 8'h08;
  localparam logic [7:0] PEC_OFF_CT2RATIO = 8'h0C;
  localparam logic [7:0] PEC_OFF_NOMSEC   = 8'h10;
  localparam logic [7:0] PEC_OFF_NOMVT    = 8'h14;
  localparam logic [7:0] PEC_OFF_GRPBASE  = 8'h20;
  localparam logic [7:0] PEC_OFF_GRPSTEP  = 8'h10;
  localparam logic [7:0] PEC_OFF_CTLSET   = 8'h80;

  // Control register fields
  localparam int PEC_CTRL_FNEN    = 0;
  localparam int PEC_CTRL_EVEN    = 1;
  localparam int PEC_CTRL_TGT_LO  = 2;
  localparam int PEC_CTRL_DIGITAL = 4;
  localparam int PEC_CTRL_CLASS   = 5;
  localparam int PEC_CTRL_CTDIFF  = 6;
  localparam int PEC_CTRL_UNDER   = 7;
  localparam int PEC_CTRL_QTY_LO  = 8;
  localparam int PEC_CTRL_USECT1  = 10;
  localparam int PEC_CTRL_USECT2  = 11;
  localparam int PEC_CTRL_WIDTH   = 12;

  // Reset values
  localparam logic [11:0] PEC_CTRL_RST  = 12'hC00;
  localparam logic [15:0] PEC_RATIO_RST = 16'h0001;
  localparam logic [15:0] PEC_NOM_RST   = 16'h0001;
  localparam logic [15:0] PEC_SET_RST   = 16'h0000;

  localparam int PEC_NUM_GROUPS = 6;
  localparam int PEC_PU_FRAC    = 8;
  localparam logic [1:0] PEC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PEC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {PEC_TGT_OFF, PEC_TGT_SELF, PEC_TGT_LATCH, PEC_TGT_RSVD} pec_tgt_t;
  typedef enum logic [1:0] {PEC_QTY_PHASE, PEC_QTY_GND, PEC_QTY_VPH, PEC_QTY_VAUX} pec_qty_t;

  typedef struct packed {
    logic [15:0] pickup;
    logic [15:0] pkpDelay;
    logic [15:0] rstDelay;
  } pec_set_t;

  typedef struct packed {
    logic signed [15:0] ct1Phase;
    logic signed [15:0] ct2Phase;
    logic signed [15:0] ct1Gnd;
    logic signed [15:0] ct2Gnd;
    logic signed [15:0] vtPhase;
    logic signed [15:0] vtAux;
  } pec_chan_t;

  typedef struct packed {
    logic pickupEvent;
    logic dropoutEvent;
    logic operateEvent;
  } pec_evt_t;

endpackage : pec_pkg

// [verification/pec_chan_src.sv]
/*
  Measurement channel source that stands in for the instrument transformers.
  Assumes the bench sets one signed level and that the samples are in secondary units.
*/
`timescale 1ns/1ps
`default_nettype none

module pec_chan_src
  import pec_pkg::*;
(
  input  wire logic signed [15:0] level,
  output pec_chan_t               chan
);
  // Unused channels carry the inverse level so a wrong selection shows
  assign chan.ct1Phase = level;
  assign chan.ct2Phase = ~level;
  assign chan.ct1Gnd   = ~level;
  assign chan.ct2Gnd   = ~level;
  assign chan.vtPhase  = ~level;
  assign chan.vtAux    = ~level;
endmodule : pec_chan_src

`default_nettype wire

// [verification/pec_comparator_bench.sv]
/*
  Self-checking bench for the comparator: register bus, timing, run, target.
  Assumes the design package and the channel source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module pec_comparator_bench;
  import pec_pkg::*;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata;
  logic               tick = 1'b0, runIn = 1'b0, blockIn = 1'b0, resetCmd = 1'b0, digitalIn = 1'b0;
  logic [2:0]         activeGroup = 3'h1;
  logic signed [15:0] level = 16'sh0000;
  pec_chan_t          chan;
  logic               pickupFlag, operateFlag, targetOut;
  pec_evt_t           events;
  int                 num_errors = 0;
  int                 comparisons = 0;

  always #2 clk = ~clk;

  pec_chan_src u_pec_chan_src (.level(level), .chan(chan));

  pec_comparator u_pec_comparator (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tick(tick), .runIn(runIn), .blockIn(blockIn), .digitalIn(digitalIn), .resetCmd(resetCmd),
    .activeGroup(activeGroup), .chan(chan), .pickupFlag(pickupFlag), .operateFlag(operateFlag),
    .targetOut(targetOut), .events(events)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : axr

  // One evaluation tick, then pickup, operate, target and the three event pulses
  task automatic tk(input logic [5:0] exp);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
    chk("flags", {26'h0, exp}, {26'h0, pickupFlag, operateFlag, targetOut, events});
    @(posedge clk);
  endtask : tk

  task automatic t_regs;
    axr(PEC_OFF_CTRL, 32'h00000C00, PEC_RESP_OKAY);
    axr(8'hF0, 32'h0, PEC_RESP_SLVERR);
    axw(8'hF0, 32'h1, PEC_RESP_SLVERR);
    runIn <= 1'b1;
    level <= 16'sh0002;
    tk(6'b000000);
  endtask : t_regs

  task automatic t_delay;
    axw(PEC_OFF_GRPBASE, 32'h100, PEC_RESP_OKAY);
    axw(8'h24, 32'h2, PEC_RESP_OKAY);
    axw(8'h28, 32'h1, PEC_RESP_OKAY);
    axw(PEC_OFF_CTRL, 32'h407, PEC_RESP_OKAY);
    tk(6'b100100);
    tk(6'b100000);
    tk(6'b111001);
    level <= 16'sh0000;
    tk(6'b011010);
    tk(6'b000000);
  endtask : t_delay

  task automatic t_run;
    level <= 16'sh0002;
    tk(6'b100100);
    tk(6'b100000);
    tk(6'b111001);
    blockIn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("flags", 32'h0, {26'h0, pickupFlag, operateFlag, targetOut, events});
    @(posedge clk);
    blockIn <= 1'b0;
    runIn   <= 1'b0;
    tk(6'b000000);
    runIn <= 1'b1;
  endtask : t_run

  task automatic t_latch;
    axw(8'h30, 32'h100, PEC_RESP_OKAY);
    axw(8'h34, 32'h0, PEC_RESP_OKAY);
    axw(8'h38, 32'h0, PEC_RESP_OKAY);
    axw(PEC_OFF_CTRL, 32'h409, PEC_RESP_OKAY);
    activeGroup <= 3'h2;
    tk(6'b111000);
    level <= 16'sh0000;
    tk(6'b001000);
    resetCmd <= 1'b1;
    @(posedge clk);
    resetCmd <= 1'b0;
    @(negedge clk);
    chk("target", 32'h0, {31'h0, targetOut});
    @(posedge clk);
  endtask : t_latch

  // Control class, nominal bases, ratio match, polarity, quantity select, digital input
  task automatic t_source;
    level <= 16'sh0002;
    axw(PEC_OFF_CTLSET, 32'h300, PEC_RESP_OKAY);
    axw(PEC_OFF_CTRL, 32'h421, PEC_RESP_OKAY);
    tk(6'b000000);
    axw(PEC_OFF_CTRL, 32'h401, PEC_RESP_OKAY);
    tk(6'b110000);
    axw(PEC_OFF_NOMSEC, 32'h4, PEC_RESP_OKAY);
    axr(PEC_OFF_NOMSEC, 32'h4, PEC_RESP_OKAY);
    tk(6'b000000);
    axw(PEC_OFF_NOMVT, 32'h3, PEC_RESP_OKAY);
    axw(PEC_OFF_CTRL, 32'h201, PEC_RESP_OKAY);
    tk(6'b110000);
    axw(PEC_OFF_CT2RATIO, 32'h2, PEC_RESP_OKAY);
    axw(PEC_OFF_CTRL, 32'hC01, PEC_RESP_OKAY);
    tk(6'b000000);
    axw(PEC_OFF_CTRL, 32'hC41, PEC_RESP_OKAY);
    tk(6'b110000);
    axw(PEC_OFF_CTRL, 32'h411, PEC_RESP_OKAY);
    tk(6'b000000);
    digitalIn <= 1'b1;
    tk(6'b110000);
  endtask : t_source

  task automatic finish_test;
    $display("Errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_delay();
    t_run();
    t_latch();
    t_source();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule : pec_comparator_bench

`default_nettype wire
